/* File: hw/dpsb_stream_buffer.sv */
/*
 * Data pre-fetch stream buffer of the external memory controller.
 * Assumes demand, response and attribute ports come from logic on
 * core_clk and that the shared memory controller echoes slot and tag.
 */
// Overview of operation
// - Eight stream entries, chosen by allocation pointer
// - Entry is 128-byte line, two 64-byte halves
// - L1 hit on one half refetches other
// - Refetch only in L1 mode; L2 triggers only when off, empty or frozen
// - New stream replaces entry at allocation pointer
// - Read hitting buffer or candidate allocates X+64
// - Prefetch X+64 first, X+128 later cycle
// - Reallocation makes older requests stale, dropped
// - Never two valid outstanding per slot
// - Per-region enable bit; regions 12-15 reset one
// - Attribute writes only from supervisor mode
// - Disabled region issues no prefetches, still cached
// - L2 off, empty or frozen means L1 behaviour
// - Address hit with no data or pending request forwards, allocation continues
// - Write on active stream invalidates held data
// - Colliding prefetches discard the earlier one
`timescale 1ns/10ps
`default_nettype none
module dpsb_stream_buffer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Demand access from the caches
  input wire logic dem_valid,
  input wire logic [dpsb_pkg::ADDR_W-1:0] dem_addr,
  input wire logic dem_write,
  input wire logic dem_pfable,
  input wire logic dem_from_l1,
  input wire logic cand_hit,
  // Level-2 cache state
  input wire logic l2_enabled,
  input wire logic l2_size_nz,
  input wire logic l2_frozen,
  // Demand answer
  output logic dem_hit,
  output logic dem_wait,
  output logic fwd_valid,
  output logic [dpsb_pkg::ADDR_W-1:0] fwd_addr,
  output logic fwd_write,
  // Pre-fetch request to shared memory controller
  output logic pf_req_valid,
  input wire logic pf_req_ready,
  output logic [dpsb_pkg::ADDR_W-1:0] pf_req_addr,
  output logic [dpsb_pkg::SLOT_W-1:0] pf_req_slot,
  output logic [dpsb_pkg::TAG_W-1:0] pf_req_tag,
  output dpsb_pkg::dpsb_kind_t pf_req_kind,
  // Pre-fetch response
  input wire logic rsp_valid,
  input wire logic [dpsb_pkg::SLOT_W-1:0] rsp_slot,
  input wire logic [dpsb_pkg::TAG_W-1:0] rsp_tag,
  input wire logic rsp_ok,
  output logic stale_drop,
  // Memory attribute pre-fetch enable bits
  input wire logic mar_wr_en,
  input wire logic mar_wr_super,
  input wire logic [7:0] mar_wr_idx,
  input wire logic mar_wr_pfx,
  input wire logic [7:0] mar_rd_idx,
  output logic mar_rd_pfx,
  // Status
  output logic [dpsb_pkg::ENT_W-1:0] alloc_ptr
);
  import dpsb_pkg::*;

  dpsb_slot_if sif ();

  dpsb_slot_table u_table (
    .core_clk(core_clk),
    .nrst(nrst),
    .sif(sif)
  );

  logic [NENT-1:0] ent_v_r;
  logic [ADDR_W-HALF_BIT-1:0] ent_base_r [NENT];
  logic [ENT_W-1:0] ptr_r;
  logic [NREGION-1:0] pfx_r;
  logic out_v_r;
  logic [ADDR_W-1:0] out_addr_r;
  logic [SLOT_W-1:0] out_slot_r;
  logic [TAG_W-1:0] out_tag_r;
  dpsb_kind_t out_kind_r;
  logic h1_v_r;
  logic h2_v_r;
  logic [ADDR_W-1:0] h1_addr_r;
  logic [ADDR_W-1:0] h2_addr_r;
  logic [SLOT_W-1:0] h1_slot_r;
  logic [SLOT_W-1:0] h2_slot_r;
  logic dem_hit_r;
  logic dem_wait_r;
  logic fwd_v_r;
  logic [ADDR_W-1:0] fwd_addr_r;
  logic fwd_wr_r;
  logic mar_rd_r;

  logic hit_any;
  logic [ENT_W-1:0] hit_idx;
  logic hit_half;
  logic [ADDR_W-HALF_BIT-1:0] dem_hw;
  logic [ADDR_W-HALF_BIT-1:0] dem_lo;
  logic [SLOT_W-1:0] hslot;
  logic [SLOT_W-1:0] oslot;
  logic rd;
  logic pf_ok;
  logic l1_mode;
  logic do_alloc;
  logic do_refetch;
  logic load_free;
  logic load_h1;
  logic load_h2;
  logic [ADDR_W-1:0] x64;
  logic [ADDR_W-1:0] x128;
  logic [ADDR_W-1:0] other_addr;
  logic [SLOT_W-1:0] iss_slot;
  logic [NSLOT-1:0] kill;

  // An entry starts on any 64-byte boundary and spans two halves
  assign dem_hw = dem_addr[ADDR_W-1:HALF_BIT];
  assign dem_lo = dem_hw - (ADDR_W-HALF_BIT)'(1);

  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    hit_half = 1'b0;
    for (int i = 0; i < NENT; i++) begin
      if (ent_v_r[i] && ent_base_r[i] == dem_hw) begin
        hit_any = 1'b1;
        hit_idx = ENT_W'(i);
        hit_half = 1'b0;
      end else if (ent_v_r[i] && ent_base_r[i] == dem_lo) begin
        hit_any = 1'b1;
        hit_idx = ENT_W'(i);
        hit_half = 1'b1;
      end
    end
  end

  assign hslot = {hit_idx, hit_half};
  assign oslot = {hit_idx, ~hit_half};
  assign rd = dem_valid && !dem_write;
  assign pf_ok = dem_pfable && pfx_r[dem_addr[ADDR_W-1:REGION_LSB]];
  assign l1_mode = dem_from_l1 || !l2_enabled || !l2_size_nz ||
    l2_frozen;
  assign x64 = dem_addr + HALF_OFS;
  assign x128 = dem_addr + LINE_OFS;
  assign other_addr = hit_half ? dem_addr - HALF_OFS :
    dem_addr + HALF_OFS;

  assign do_alloc = rd && pf_ok && (hit_any || cand_hit);
  // A refetch into the entry being reallocated would fill the new stream
  assign do_refetch = rd && pf_ok && hit_any && l1_mode &&
    !sif.pend[oslot] && !sif.pres[oslot] &&
    !(do_alloc && hit_idx == ptr_r);

  assign load_free = !out_v_r || pf_req_ready;
  assign load_h1 = !do_refetch && !do_alloc && h1_v_r && load_free;
  assign load_h2 = !do_refetch && !do_alloc && !h1_v_r && h2_v_r &&
    load_free;

  always_comb begin
    if (do_refetch) begin
      iss_slot = oslot;
    end else if (load_h1) begin
      iss_slot = h1_slot_r;
    end else begin
      iss_slot = h2_slot_r;
    end
  end

  always_comb begin
    kill = '0;
    if (do_alloc) begin
      kill[{ptr_r, 1'b0}] = 1'b1;
      kill[{ptr_r, 1'b1}] = 1'b1;
    end
    if (dem_valid && dem_write && hit_any) begin
      kill[hslot] = 1'b1;
    end
  end

  assign sif.issue_v = do_refetch || load_h1 || load_h2;
  assign sif.issue_slot = iss_slot;
  assign sif.kill_mask = kill;
  assign sif.cancel_v = do_refetch && out_v_r && !pf_req_ready;
  assign sif.cancel_slot = out_slot_r;
  assign sif.cancel_tag = out_tag_r;
  assign sif.ret_v = rsp_valid;
  assign sif.ret_slot = rsp_slot;
  assign sif.ret_tag = rsp_tag;
  assign sif.ret_ok = rsp_ok;

  // Stream entries and allocation pointer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ent_v_r <= '0;
      ptr_r <= PTR_RST;
      for (int i = 0; i < NENT; i++) begin
        ent_base_r[i] <= '0;
      end
    end else if (do_alloc) begin
      ent_v_r[ptr_r] <= 1'b1;
      ent_base_r[ptr_r] <= x64[ADDR_W-1:HALF_BIT];
      ptr_r <= ptr_r + 3'h1;
    end
  end

  // Stream pre-fetches waiting for the output stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      h1_v_r <= 1'b0;
      h2_v_r <= 1'b0;
      h1_addr_r <= '0;
      h2_addr_r <= '0;
      h1_slot_r <= '0;
      h2_slot_r <= '0;
    end else if (do_alloc) begin
      h1_v_r <= 1'b1;
      h2_v_r <= 1'b1;
      h1_addr_r <= x64;
      h2_addr_r <= x128;
      h1_slot_r <= {ptr_r, 1'b0};
      h2_slot_r <= {ptr_r, 1'b1};
    end else begin
      if (load_h1) begin
        h1_v_r <= 1'b0;
      end
      if (load_h2) begin
        h2_v_r <= 1'b0;
      end
    end
  end

  // Output stage; a refetch overwrites an unaccepted request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_v_r <= 1'b0;
      out_addr_r <= '0;
      out_slot_r <= '0;
      out_tag_r <= TAG_RST;
      out_kind_r <= DPSB_KIND_REFETCH;
    end else if (sif.issue_v) begin
      out_v_r <= 1'b1;
      out_slot_r <= iss_slot;
      out_tag_r <= sif.tag[iss_slot] + 2'h1;
      if (do_refetch) begin
        out_addr_r <= other_addr;
        out_kind_r <= DPSB_KIND_REFETCH;
      end else if (load_h1) begin
        out_addr_r <= h1_addr_r;
        out_kind_r <= DPSB_KIND_FIRST;
      end else begin
        out_addr_r <= h2_addr_r;
        out_kind_r <= DPSB_KIND_SECOND;
      end
    end else if (pf_req_ready) begin
      out_v_r <= 1'b0;
    end
  end

  // Demand classification
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dem_hit_r <= 1'b0;
      dem_wait_r <= 1'b0;
      fwd_v_r <= 1'b0;
      fwd_addr_r <= '0;
      fwd_wr_r <= 1'b0;
    end else begin
      dem_hit_r <= rd && hit_any && sif.pres[hslot];
      dem_wait_r <= rd && hit_any && !sif.pres[hslot] && sif.pend[hslot];
      fwd_v_r <= dem_valid && !(rd && hit_any &&
        (sif.pres[hslot] || sif.pend[hslot]));
      fwd_addr_r <= dem_addr;
      fwd_wr_r <= dem_write;
    end
  end

  // Per-region pre-fetch enable bits
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pfx_r <= PFX_RST;
      mar_rd_r <= 1'b0;
    end else begin
      if (mar_wr_en && mar_wr_super) begin
        pfx_r[mar_wr_idx] <= mar_wr_pfx;
      end
      mar_rd_r <= pfx_r[mar_rd_idx];
    end
  end

  assign dem_hit = dem_hit_r;
  assign dem_wait = dem_wait_r;
  assign fwd_valid = fwd_v_r;
  assign fwd_addr = fwd_addr_r;
  assign fwd_write = fwd_wr_r;
  assign pf_req_valid = out_v_r;
  assign pf_req_addr = out_addr_r;
  assign pf_req_slot = out_slot_r;
  assign pf_req_tag = out_tag_r;
  assign pf_req_kind = out_kind_r;
  assign stale_drop = sif.stale;
  assign mar_rd_pfx = mar_rd_r;
  assign alloc_ptr = ptr_r;
endmodule
`default_nettype wire

/* File: hw/dpsb_pkg.sv */
/*
 * Shared constants and types of the data pre-fetch stream buffer.
 * Assumes a 32-bit byte address and 16 MB attribute regions.
 */
package dpsb_pkg;
  localparam int ADDR_W = 32;
  localparam int NENT = 8;
  localparam int ENT_W = 3;
  localparam int NSLOT = 16;
  localparam int SLOT_W = 4;
  localparam int TAG_W = 2;
  localparam int LINE_LSB = 7;
  localparam int HALF_BIT = 6;
  localparam int REGION_LSB = 24;
  localparam int NREGION = 256;
  localparam logic [ADDR_W-1:0] HALF_OFS = 32'h0000_0040;
  localparam logic [ADDR_W-1:0] LINE_OFS = 32'h0000_0080;
  // Regions 12..15 (0x0c000000 upward) power up pre-fetch enabled
  localparam logic [NREGION-1:0] PFX_RST = 256'h0000_f000;
  localparam logic [ENT_W-1:0] PTR_RST = 3'h0;
  localparam logic [TAG_W-1:0] TAG_RST = 2'h0;

  typedef enum logic [2:0] {
    DPSB_KIND_REFETCH = 3'b001,
    DPSB_KIND_FIRST = 3'b010,
    DPSB_KIND_SECOND = 3'b100
  } dpsb_kind_t;
endpackage

/* File: hw/dpsb_slot_if.sv */
/*
 * Carrier between the stream buffer top and its slot state table.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface dpsb_slot_if;
  import dpsb_pkg::*;
  logic issue_v;
  logic [SLOT_W-1:0] issue_slot;
  logic [NSLOT-1:0] kill_mask;
  logic cancel_v;
  logic [SLOT_W-1:0] cancel_slot;
  logic [TAG_W-1:0] cancel_tag;
  logic ret_v;
  logic [SLOT_W-1:0] ret_slot;
  logic [TAG_W-1:0] ret_tag;
  logic ret_ok;
  logic [NSLOT-1:0] pend;
  logic [NSLOT-1:0] pres;
  logic [NSLOT-1:0][TAG_W-1:0] tag;
  logic stale;

  modport store (input issue_v, issue_slot, kill_mask, cancel_v,
    cancel_slot, cancel_tag, ret_v, ret_slot, ret_tag, ret_ok,
    output pend, pres, tag, stale);
  modport user (output issue_v, issue_slot, kill_mask, cancel_v,
    cancel_slot, cancel_tag, ret_v, ret_slot, ret_tag, ret_ok,
    input pend, pres, tag, stale);
endinterface
`default_nettype wire

/* File: hw/dpsb_slot_table.sv */
/*
 * Per-half slot state: outstanding flag, request tag, data present.
 * Assumes the top gives each issued request the tag current plus one.
 */
`timescale 1ns/10ps
`default_nettype none
module dpsb_slot_table (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Slot operations
  dpsb_slot_if.store sif
);
  import dpsb_pkg::*;

  logic [NSLOT-1:0] pend_r;
  logic [NSLOT-1:0] pres_r;
  logic [NSLOT-1:0][TAG_W-1:0] tag_r;
  logic stale_r;
  logic [NSLOT-1:0] match;
  logic [NSLOT-1:0] cmatch;

  always_comb begin
    for (int s = 0; s < NSLOT; s++) begin
      // Same-cycle issue or kill already supersedes the returning tag
      match[s] = sif.ret_v && sif.ret_slot == SLOT_W'(s) && pend_r[s] &&
        sif.ret_tag == tag_r[s] && !sif.kill_mask[s] &&
        !(sif.issue_v && sif.issue_slot == SLOT_W'(s));
      cmatch[s] = sif.cancel_v && sif.cancel_slot == SLOT_W'(s) &&
        sif.cancel_tag == tag_r[s];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tag_r <= '0;
      pend_r <= '0;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (sif.kill_mask[s] ||
            (sif.issue_v && sif.issue_slot == SLOT_W'(s))) begin
          tag_r[s] <= tag_r[s] + 2'h1;
        end
        if (sif.issue_v && sif.issue_slot == SLOT_W'(s)) begin
          pend_r[s] <= 1'b1;
        end else if (sif.kill_mask[s] || match[s] || cmatch[s]) begin
          pend_r[s] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pres_r <= '0;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (sif.kill_mask[s]) begin
          pres_r[s] <= 1'b0;
        end else if (match[s] && sif.ret_ok) begin
          pres_r[s] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stale_r <= 1'b0;
    end else begin
      stale_r <= sif.ret_v && !(|match);
    end
  end

  assign sif.pend = pend_r;
  assign sif.pres = pres_r;
  assign sif.tag = tag_r;
  assign sif.stale = stale_r;
endmodule
`default_nettype wire

/* File: testbench/dpsb_checker.sv */
/* Port checker for the stream buffer top.
   Assumes a bind from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
module dpsb_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic dem_valid,
  input wire logic dem_write,
  input wire logic dem_pfable,
  input wire logic dem_from_l1,
  input wire logic l2_enabled,
  input wire logic l2_size_nz,
  input wire logic l2_frozen,
  input wire logic dem_hit,
  input wire logic dem_wait,
  input wire logic fwd_valid,
  input wire logic pf_req_valid,
  input wire logic pf_req_ready,
  input wire logic [dpsb_pkg::ADDR_W-1:0] pf_req_addr,
  input wire dpsb_pkg::dpsb_kind_t pf_req_kind,
  input wire logic rsp_valid,
  input wire logic stale_drop,
  input wire logic [dpsb_pkg::ENT_W-1:0] alloc_ptr
);
  import dpsb_pkg::*;
  logic l1m;
  logic rf;
  logic [ADDR_W-1:0] first_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  assign l1m = dem_from_l1 | !l2_enabled | !l2_size_nz | l2_frozen;
  assign rf = pf_req_valid && pf_req_kind == DPSB_KIND_REFETCH;
  // Address of the last first-stream request seen
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      first_r <= '0;
    end else if (pf_req_valid && pf_req_kind == DPSB_KIND_FIRST) begin
      first_r <= pf_req_addr;
    end
  end
  a_hit_cause: assert property (dem_hit |-> $past(dem_valid))
    else $error("hit without demand");
  a_hit_nofwd: assert property (
    (dem_hit || dem_wait) && !$past(dem_write) |-> !fwd_valid)
    else $error("buffered read forwarded");
  a_write_fwd: assert property (
    dem_valid && dem_write |=> fwd_valid) else $error("write held back");
  a_l2_norefetch: assert property (
    rf && !$past(pf_req_valid) |-> $past(dem_valid && !dem_write && l1m))
    else $error("refetch without level-1 read");
  a_req_hold: assert property (
    pf_req_valid && !pf_req_ready |=> pf_req_valid)
    else $error("request lost");
  a_second_addr: assert property (
    pf_req_valid && pf_req_kind == DPSB_KIND_SECOND
    |-> pf_req_addr == first_r + HALF_OFS) else $error("second address");
  a_alloc_step: assert property (
    alloc_ptr != $past(alloc_ptr) |-> alloc_ptr == $past(alloc_ptr) + 3'h1
    && $past(dem_valid && dem_pfable && !dem_write))
    else $error("pointer step");
  a_stale_cause: assert property (stale_drop |-> $past(rsp_valid))
    else $error("drop without response");
  c_refetch: cover property (rf);
  c_stale: cover property (stale_drop);
  c_hit: cover property (dem_hit);
endmodule
`default_nettype wire

/* File: testbench/dpsb_mem_model.sv */
/* Shared memory controller model: accepts requests, echoes slot and tag.
   Assumes one clock; the bench drives hold and slow. */
`timescale 1ns/10ps
`default_nettype none
module dpsb_mem_model (
  // Clock and pacing
  input wire logic core_clk,
  input wire logic hold,
  input wire logic slow,
  // Requests
  input wire logic pf_req_valid,
  output var logic pf_req_ready,
  input wire logic [dpsb_pkg::SLOT_W-1:0] pf_req_slot,
  input wire logic [dpsb_pkg::TAG_W-1:0] pf_req_tag,
  // Responses
  output var logic rsp_valid,
  output var logic [dpsb_pkg::SLOT_W-1:0] rsp_slot,
  output var logic [dpsb_pkg::TAG_W-1:0] rsp_tag,
  output var logic rsp_ok
);
  import dpsb_pkg::*;
  logic [SLOT_W+TAG_W-1:0] q[$];
  initial begin
    {pf_req_ready, rsp_valid, rsp_slot, rsp_tag, rsp_ok} = '0;
  end
  always @(posedge core_clk) begin
    if (pf_req_valid && pf_req_ready) begin
      q.push_back({pf_req_slot, pf_req_tag});
    end
  end
  // Idle response lines keep changing so nothing stale looks valid
  always @(negedge core_clk) begin
    pf_req_ready <= slow ? !pf_req_ready : 1'b1;
    if (!hold && q.size() > 0) begin
      {rsp_slot, rsp_tag} <= q.pop_front();
      {rsp_valid, rsp_ok} <= 2'h3;
    end else begin
      rsp_valid <= 1'b0;
      {rsp_slot, rsp_tag, rsp_ok} <= {~rsp_slot, ~rsp_tag, ~rsp_ok};
    end
  end
endmodule
`default_nettype wire

/* File: testbench/data_prefetch_stream_buffer_tb.sv */
/* Self-checking bench of the stream buffer with a memory model.
   Assumes the checker and model files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module data_prefetch_stream_buffer_tb;
  import dpsb_pkg::*;
  logic core_clk = 1'b0;
  logic nrst, dem_valid, dem_write, dem_pfable, dem_from_l1, cand_hit;
  logic l2_enabled, l2_size_nz, l2_frozen, dem_hit, dem_wait, fwd_valid;
  logic pf_req_valid, pf_req_ready, rsp_valid, rsp_ok, stale_drop;
  logic mar_wr_en, mar_wr_super, mar_wr_pfx, mar_rd_pfx, hold, slow;
  logic fwd_write;
  logic [ADDR_W-1:0] dem_addr, pf_req_addr, fwd_addr;
  logic [SLOT_W-1:0] pf_req_slot, rsp_slot;
  logic [TAG_W-1:0] pf_req_tag, rsp_tag;
  logic [7:0] mar_wr_idx, mar_rd_idx;
  logic [ENT_W-1:0] alloc_ptr;
  dpsb_kind_t pf_req_kind;
  logic [ADDR_W+2:0] acc[$];
  int errors = 0, compares = 0, nstale = 0;
  always #10 core_clk = ~core_clk;
  dpsb_stream_buffer u_dut (.core_clk, .nrst, .dem_valid, .dem_addr,
    .dem_write, .dem_pfable, .dem_from_l1, .cand_hit, .l2_enabled,
    .l2_size_nz, .l2_frozen, .dem_hit, .dem_wait, .fwd_valid,
    .fwd_addr, .fwd_write, .pf_req_valid, .pf_req_ready,
    .pf_req_addr, .pf_req_slot, .pf_req_tag, .pf_req_kind, .rsp_valid,
    .rsp_slot, .rsp_tag, .rsp_ok, .stale_drop, .mar_wr_en, .mar_wr_super,
    .mar_wr_idx, .mar_wr_pfx, .mar_rd_idx, .mar_rd_pfx, .alloc_ptr);
  dpsb_mem_model u_mem (.core_clk, .hold, .slow, .pf_req_valid,
    .pf_req_ready, .pf_req_slot, .pf_req_tag, .rsp_valid, .rsp_slot,
    .rsp_tag, .rsp_ok);
  // Log of accepted requests and dropped responses
  always @(posedge core_clk) begin
    if (pf_req_valid && pf_req_ready) begin
      acc.push_back({pf_req_kind, pf_req_addr});
    end
    if (stale_drop) begin
      nstale++;
    end
  end
  task automatic end_of_test;
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [ADDR_W+2:0] e, logic [ADDR_W+2:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One demand pulse; r is {hit, wait, forward} one cycle later
  task automatic dem(logic [ADDR_W-1:0] a, logic w, l1, ch,
    output logic [2:0] r);
    @(negedge core_clk);
    {dem_valid, dem_addr, dem_write} = {1'b1, a, w};
    {dem_from_l1, cand_hit} = {l1, ch};
    @(negedge core_clk);
    dem_valid = 1'b0;
    r = {dem_hit, dem_wait, fwd_valid};
  endtask
  task automatic mar_wr(logic [7:0] i, logic s, p);
    @(negedge core_clk);
    {mar_wr_en, mar_wr_idx, mar_wr_super, mar_wr_pfx} = {1'b1, i, s, p};
    @(negedge core_clk);
    mar_wr_en = 1'b0;
  endtask
  task automatic mar_chk(logic [7:0] i, logic e);
    @(negedge core_clk);
    mar_rd_idx = i;
    @(negedge core_clk);
    chk("mar_rd_pfx", e, mar_rd_pfx);
  endtask
  task automatic t_mar;
    chk("alloc_ptr", 3'h0, alloc_ptr);
    mar_chk(8'h0b, 1'b0);
    mar_chk(8'h0c, 1'b1);
    mar_chk(8'h0f, 1'b1);
    mar_chk(8'h10, 1'b0);
    mar_wr(8'h20, 1'b0, 1'b1);
    mar_chk(8'h20, 1'b0);
    mar_wr(8'h20, 1'b1, 1'b1);
    mar_chk(8'h20, 1'b1);
    mar_wr(8'h20, 1'b1, 1'b0);
    mar_chk(8'h20, 1'b0);
  endtask
  task automatic t_disabled;
    logic [2:0] r;
    acc.delete();
    dem(32'h2100_0000, 1'b0, 1'b1, 1'b1, r);
    chk("forward", 3'b001, r);
    repeat (6) @(negedge core_clk);
    chk("requests", 35'h0, 35'(acc.size()));
  endtask
  task automatic t_alloc;
    logic [2:0] r;
    acc.delete();
    dem(32'h0c00_0fc0, 1'b0, 1'b0, 1'b1, r);
    chk("forward", 3'b001, r);
    chk("alloc_ptr", 3'h1, alloc_ptr);
    repeat (12) @(negedge core_clk);
    chk("first", {DPSB_KIND_FIRST, 32'h0c00_1000}, acc.pop_front());
    chk("second", {DPSB_KIND_SECOND, 32'h0c00_1040}, acc.pop_front());
  endtask
  // Invalidate half 0 of a filled line, then read half 1
  task automatic t_refetch(logic [ADDR_W-1:0] b, logic l1, fz, rf);
    logic [2:0] r;
    {l2_frozen, slow} = {fz, fz};
    dem(b, 1'b1, l1, 1'b0, r);
    chk("write forward", 1'b1, r[0]);
    chk("fwd_addr", b, fwd_addr);
    chk("fwd_write", 1'b1, fwd_write);
    acc.delete();
    dem(b + HALF_OFS, 1'b0, l1, 1'b0, r);
    chk("read hit", 3'b100, r);
    repeat (12) @(negedge core_clk);
    if (rf) begin
      chk("refetch", {DPSB_KIND_REFETCH, b}, acc.pop_front());
    end
    chk("first", {DPSB_KIND_FIRST, b + LINE_OFS}, acc.pop_front());
    chk("second", {DPSB_KIND_SECOND, b + LINE_OFS + HALF_OFS},
      acc.pop_front());
    {l2_frozen, slow} = 2'h0;
  endtask
  // Nine streams with responses held: the ninth reuses a busy entry
  task automatic t_stale;
    logic [2:0] r;
    hold = 1'b1;
    nstale = 0;
    for (int i = 0; i < 9; i++) begin
      dem(32'h0d00_0f80 + 32'(i) * 32'h1000, 1'b0, 1'b0, 1'b1, r);
      repeat (3) @(negedge core_clk);
    end
    chk("alloc_ptr", 3'h5, alloc_ptr);
    // Early half of the eighth stream still outstanding
    dem_pfable = 1'b0;
    dem(32'h0d00_7fc0, 1'b0, 1'b0, 1'b0, r);
    chk("hit wait", 3'b010, r);
    dem_pfable = 1'b1;
    hold = 1'b0;
    repeat (40) @(negedge core_clk);
    chk("stale drops", 35'h2, 35'(nstale));
    dem(32'h0d00_9000, 1'b0, 1'b0, 1'b0, r);
    chk("new stream hit", 3'b100, r);
  endtask
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    {nrst, dem_valid, dem_write, dem_from_l1, cand_hit, l2_frozen} = '0;
    {mar_wr_en, mar_wr_super, hold, slow, dem_addr} = '0;
    {mar_wr_idx, mar_rd_idx} = '0;
    {dem_pfable, l2_enabled, l2_size_nz, mar_wr_pfx} = 4'hf;
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    t_mar();
    t_disabled();
    t_alloc();
    t_refetch(32'h0c00_1000, 1'b1, 1'b0, 1'b1);
    t_refetch(32'h0c00_1080, 1'b0, 1'b0, 1'b0);
    t_refetch(32'h0c00_1100, 1'b0, 1'b1, 1'b1);
    t_stale();
    end_of_test();
  end
endmodule
bind dpsb_stream_buffer dpsb_checker u_chk (.core_clk, .nrst, .dem_valid,
  .dem_write, .dem_pfable, .dem_from_l1, .l2_enabled, .l2_size_nz,
  .l2_frozen, .dem_hit, .dem_wait, .fwd_valid, .pf_req_valid, .pf_req_ready,
  .pf_req_addr, .pf_req_kind, .rsp_valid, .stale_drop, .alloc_ptr);
`default_nettype wire
